// file: hdl/port_ctrl_regs.vh
// Purpose: constants for the per-port basic control register and its serial management port
// Assumes: 40 MHz core clock, management clock sampled as an ordinary input
// Notes: field positions are bit indices within the 16-bit control word
`ifndef PORT_CTRL_REGS_VH
`define PORT_CTRL_REGS_VH

// register address within the management space
`define CTRL_REG_ADDR 5'h00

// control word field positions
`define CTRL_SOFT_RST 15
`define CTRL_LOOPBACK 14
`define CTRL_SPEED 13
`define CTRL_AN_EN 12
`define CTRL_PWR_DOWN 11
`define CTRL_ISOLATE 10
`define CTRL_AN_RESTART 9
`define CTRL_DUPLEX 8

// reset values of the stored bits that reset to one
`define CTRL_SPEED_RST 1'h1
`define CTRL_AN_EN_RST 1'h1
`define CTRL_DUPLEX_RST 1'h1

// management frame
`define MGMT_PREAMBLE_BITS 6'h20
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_HDR_LAST 6'h0d
`define MGMT_TA_FIRST 6'h0e
`define MGMT_DATA_LAST 6'h1e
`define MGMT_FRAME_LAST 6'h1f

// timing
`define SOFT_RST_TIME_NS 400
`define CLK_PERIOD_NS 25
`define SOFT_RST_CYCLES 8'h10
`define STRAP_SETTLE_CYCLES 3'h5

`endif

// file: hdl/port_ctrl.v
// Purpose: per-port basic control register reached over the serial management port
// Assumes: mgmt clock well below core clock; an_speed/an_duplex come from on-chip logic
// Notes: mdio is split into input, output and output enable
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_regs.vh"

module port_ctrl (
  input wire core_clk, // core clock, 40 MHz
  input wire rst_b, // chip reset, active low
  input wire [4:0] phy_addr, // this port's management address
  input wire mdc, // management clock pin
  input wire mdio_i, // management data pin level
  output reg mdio_o, // management data drive value
  output reg mdio_oe, // high while driving mdio
  input wire fiber_mode, // pin: port configured for 100 megabit fiber
  input wire direct_led, // pin: direct LED mode enabled
  input wire duplex_strap, // pin: fiber duplex strap level
  input wire an_speed_100, // negotiated speed, one = 100 megabit
  input wire an_full_duplex, // negotiated duplex, one = full
  input wire tx_from_mac, // transmit data from MAC interface
  input wire rx_from_line, // receive data from the line side
  output reg rx_to_mac, // receive data toward MAC interface
  output reg tx_to_line, // transmit data toward the line side
  output reg port_rst, // port logic held in reset
  output reg port_enable, // port functions powered
  output reg an_enable, // negotiation running
  output reg an_restart, // one-cycle negotiation restart
  output reg link_speed_100, // speed in use
  output reg link_full_duplex // duplex in use
);

  // ==========================================
  // reset release
  reg rst_s1_q, rst_q;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_q;

  // ==========================================
  // pin synchronisers, change accepted when stages 2 and 3 agree
  reg [2:0] mdc_sh_q, mdio_sh_q, fib_sh_q, led_sh_q, strap_sh_q;
  reg mdc_f_q, mdio_f_q, fib_f_q, led_f_q, strap_f_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_sh_q <= 3'h0;
      mdio_sh_q <= 3'h7;
      fib_sh_q <= 3'h0;
      led_sh_q <= 3'h0;
      strap_sh_q <= 3'h0;
      mdc_f_q <= 1'b0;
      mdio_f_q <= 1'b1;
      fib_f_q <= 1'b0;
      led_f_q <= 1'b0;
      strap_f_q <= 1'b0;
    end else begin
      mdc_sh_q <= {mdc_sh_q[1:0], mdc};
      mdio_sh_q <= {mdio_sh_q[1:0], mdio_i};
      fib_sh_q <= {fib_sh_q[1:0], fiber_mode};
      led_sh_q <= {led_sh_q[1:0], direct_led};
      strap_sh_q <= {strap_sh_q[1:0], duplex_strap};
      if (mdc_sh_q[1] == mdc_sh_q[2]) mdc_f_q <= mdc_sh_q[2];
      if (mdio_sh_q[1] == mdio_sh_q[2]) mdio_f_q <= mdio_sh_q[2];
      if (fib_sh_q[1] == fib_sh_q[2]) fib_f_q <= fib_sh_q[2];
      if (led_sh_q[1] == led_sh_q[2]) led_f_q <= led_sh_q[2];
      if (strap_sh_q[1] == strap_sh_q[2]) strap_f_q <= strap_sh_q[2];
    end
  end
  wire mdc_rise = (mdc_sh_q[1] == mdc_sh_q[2]) && mdc_sh_q[2] && !mdc_f_q;
  wire mdio_bit = mdio_f_q;

  // ==========================================
  // control state
  reg soft_rst_q, loop_q, spd_man_q, an_en_q, pd_q, iso_q, restart_q, dup_man_q;
  reg dup_def_q, strap_done_q;
  reg [2:0] strap_cnt_q;
  reg [7:0] srst_cnt_q;
  reg wr_stb;
  reg [15:0] wr_data;

  // held off until the fiber pin level has passed its filter
  wire an_on = an_en_q && !fib_f_q && strap_done_q;
  wire spd_eff = an_on ? an_speed_100 : spd_man_q;
  wire dup_eff = an_on ? an_full_duplex : dup_man_q;
  // reads show the speed and duplex in use, low byte zero
  wire [15:0] ctrl_rd = {soft_rst_q, loop_q, spd_eff, an_on, pd_q, iso_q, restart_q,
                         dup_eff, 8'h00};
  wire srst_done = soft_rst_q && (srst_cnt_q == `SOFT_RST_CYCLES);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_q <= 1'b0;
      loop_q <= 1'b0;
      spd_man_q <= `CTRL_SPEED_RST;
      an_en_q <= `CTRL_AN_EN_RST;
      pd_q <= 1'b0;
      iso_q <= 1'b0;
      restart_q <= 1'b0;
      dup_man_q <= `CTRL_DUPLEX_RST;
      dup_def_q <= `CTRL_DUPLEX_RST;
      strap_done_q <= 1'b0;
      strap_cnt_q <= 3'h0;
      srst_cnt_q <= 8'h00;
    end else begin
      restart_q <= 1'b0;
      if (!strap_done_q) begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
        if (strap_cnt_q == `STRAP_SETTLE_CYCLES) begin
          strap_done_q <= 1'b1;
          if (fib_f_q && !led_f_q) begin
            dup_def_q <= strap_f_q;
            dup_man_q <= strap_f_q;
          end
        end
      end
      if (soft_rst_q) srst_cnt_q <= srst_cnt_q + 8'h01;
      if (srst_done) begin
        soft_rst_q <= 1'b0;
        srst_cnt_q <= 8'h00;
        loop_q <= 1'b0;
        spd_man_q <= `CTRL_SPEED_RST;
        an_en_q <= `CTRL_AN_EN_RST;
        pd_q <= 1'b0;
        iso_q <= 1'b0;
        dup_man_q <= dup_def_q;
      end else if (wr_stb) begin
        if (wr_data[`CTRL_SOFT_RST]) soft_rst_q <= 1'b1;
        loop_q <= wr_data[`CTRL_LOOPBACK];
        spd_man_q <= wr_data[`CTRL_SPEED];
        if (!fib_f_q) an_en_q <= wr_data[`CTRL_AN_EN];
        pd_q <= wr_data[`CTRL_PWR_DOWN];
        iso_q <= wr_data[`CTRL_ISOLATE];
        restart_q <= wr_data[`CTRL_AN_RESTART];
        dup_man_q <= wr_data[`CTRL_DUPLEX];
      end
    end
  end

  // ==========================================
  // port outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_to_mac <= 1'b0;
      tx_to_line <= 1'b0;
      port_rst <= 1'b1;
      port_enable <= 1'b0;
      an_enable <= 1'b0;
      an_restart <= 1'b0;
      link_speed_100 <= 1'b0;
      link_full_duplex <= 1'b0;
    end else begin
      port_rst <= soft_rst_q;
      port_enable <= !pd_q;
      an_enable <= an_on && !pd_q;
      an_restart <= restart_q && an_on;
      link_speed_100 <= spd_eff;
      link_full_duplex <= dup_eff;
      // isolate and power-down gate the MAC side, loopback folds tx into rx
      if (iso_q || pd_q || soft_rst_q) rx_to_mac <= 1'b0;
      else if (loop_q) rx_to_mac <= tx_from_mac;
      else rx_to_mac <= rx_from_line;
      if (iso_q || pd_q || loop_q || soft_rst_q) tx_to_line <= 1'b0;
      else tx_to_line <= tx_from_mac;
    end
  end

  // ==========================================
  // management frame engine
  localparam S_IDLE = 1'b0;
  localparam S_FRAME = 1'b1;
  reg state_q, seen_frame_q, rd_q, wr_q;
  reg [5:0] pre_cnt_q, bit_cnt_q;
  reg [12:0] hdr_q;
  reg [15:0] sh_q;
  wire [13:0] hdr = {hdr_q, mdio_bit};
  wire hdr_ok = (hdr[13:12] == 2'h1) && (hdr[9:5] == phy_addr) &&
                ((hdr[11:10] == `MGMT_OP_READ) || (hdr[11:10] == `MGMT_OP_WRITE));
  wire pre_ok = (pre_cnt_q == `MGMT_PREAMBLE_BITS) || seen_frame_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      seen_frame_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 6'h00;
      hdr_q <= 13'h0000;
      sh_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          S_IDLE: begin
            if (!mdio_bit && pre_ok) begin
              state_q <= S_FRAME;
              bit_cnt_q <= 6'h01;
              hdr_q <= 13'h0000;
            end
            if (mdio_bit) begin
              if (pre_cnt_q != `MGMT_PREAMBLE_BITS) pre_cnt_q <= pre_cnt_q + 6'h01;
            end else begin
              pre_cnt_q <= 6'h00;
            end
          end
          S_FRAME: begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q <= `MGMT_HDR_LAST) hdr_q <= hdr[12:0];
            if (bit_cnt_q == `MGMT_HDR_LAST) begin
              rd_q <= 1'b0;
              sh_q <= 16'h0000;
              // header is complete only here, so the write decision is kept
              wr_q <= hdr_ok && (hdr[11:10] == `MGMT_OP_WRITE) &&
                      (hdr[4:0] == `CTRL_REG_ADDR);
              if (hdr_ok && hdr[11:10] == `MGMT_OP_READ) begin
                rd_q <= 1'b1;
                sh_q <= (hdr[4:0] == `CTRL_REG_ADDR) ? ctrl_rd : 16'h0000;
              end
            end
            // read: drive turnaround zero then sixteen data bits
            if (rd_q && bit_cnt_q == `MGMT_TA_FIRST) begin
              mdio_oe <= 1'b1;
              mdio_o <= 1'b0;
            end else if (rd_q && bit_cnt_q > `MGMT_TA_FIRST && bit_cnt_q <= `MGMT_DATA_LAST) begin
              mdio_o <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end else if (!rd_q && bit_cnt_q > `MGMT_TA_FIRST + 6'h01) begin
              sh_q <= {sh_q[14:0], mdio_bit};
            end
            if (bit_cnt_q == `MGMT_FRAME_LAST) begin
              state_q <= S_IDLE;
              seen_frame_q <= 1'b1;
              pre_cnt_q <= 6'h00;
              mdio_oe <= 1'b0;
              mdio_o <= 1'b0;
              if (wr_q) begin
                wr_stb <= 1'b1;
                wr_data <= {sh_q[14:0], mdio_bit} & 16'hff00;
              end
              rd_q <= 1'b0;
              wr_q <= 1'b0;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/port_ctrl_props.sv
// Purpose: pin-level checks of port_ctrl
// Assumes: one clock, rst_b low active
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_props (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic [4:0] phy_addr, // address
  input wire logic mdc, // mgmt clock
  input wire logic mdio_i, // mdio in
  input wire logic mdio_o, // mdio out
  input wire logic mdio_oe, // mdio drive
  input wire logic fiber_mode, // fiber
  input wire logic direct_led, // led mode
  input wire logic duplex_strap, // strap
  input wire logic an_speed_100, // neg speed
  input wire logic an_full_duplex, // neg duplex
  input wire logic tx_from_mac, // mac tx
  input wire logic rx_from_line, // line rx
  input wire logic rx_to_mac, // mac rx
  input wire logic tx_to_line, // line tx
  input wire logic port_rst, // port reset
  input wire logic port_enable, // powered
  input wire logic an_enable, // neg on
  input wire logic an_restart, // restart
  input wire logic link_speed_100, // speed
  input wire logic link_full_duplex // duplex
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // data path
  loop_tx_a: assert property (tx_to_line |-> $past(tx_from_mac))
    else $error("line tx without mac tx");
  rx_source_a: assert property (rx_to_mac |-> $past(tx_from_mac) || $past(rx_from_line))
    else $error("mac rx without source");
  pwr_dn_quiet_a: assert property (!port_enable |-> !rx_to_mac && !tx_to_line)
    else $error("data moves while powered down");
  soft_rst_quiet_a: assert property (port_rst |-> !rx_to_mac && !tx_to_line)
    else $error("data moves in port reset");
  soft_rst_len_a: assert property ($rose(port_rst) |->
    port_rst [*8] ##1 port_rst [*7] ##[1:4] !port_rst) else $error("soft reset length");
  // ==========
  // negotiation
  restart_pulse_a: assert property (an_restart |=> !an_restart)
    else $error("restart longer than a cycle");
  an_follow_a: assert property (an_enable |-> link_speed_100 == $past(an_speed_100) &&
    link_full_duplex == $past(an_full_duplex)) else $error("link ignores negotiation");
  an_gate_a: assert property (an_enable |-> port_enable && !fiber_mode)
    else $error("negotiation on when barred");
  // ==========
  // management answer
  turn_zero_a: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not zero");
  drive_len_a: assert property ($rose(mdio_oe) |-> ##260 mdio_oe ##[1:30] !mdio_oe)
    else $error("read drive length");
endmodule
`default_nettype wire

// file: tb/mac_mgmt.sv
// Purpose: station management master on the serial management port
// Assumes: mgmt clock of 16 core cycles, mdio pulled up when released
// Notes: frame task called by the bench; rd_valid flags a read word
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_regs.vh"
module mac_mgmt (
  input wire logic core_clk, // core clock
  input wire logic mdio_wire, // resolved mdio level
  output var logic mdc, // mgmt clock
  output var logic mdio_m, // drive value
  output var logic mdio_m_oe, // drive enable
  output var logic rd_valid, // read word ready
  output var logic [15:0] rd_data // read word
);
  initial begin
    mdc = 1'b0;
    mdio_m = 1'b1;
    mdio_m_oe = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  task automatic bit_cyc(input logic drv, input logic val, output logic smp);
    mdio_m <= val;
    mdio_m_oe <= drv;
    repeat (8) @(posedge core_clk);
    mdc <= 1'b1; // 8 low plus 8 high: 2.5 MHz
    repeat (8) @(posedge core_clk);
    smp = mdio_wire;
    mdc <= 1'b0;
  endtask
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] f;
    logic [15:0] r;
    logic s;
    f = {2'b01, op, pa, ra, 2'b10, wd};
    if (pre) begin
      repeat (32) bit_cyc(1'b1, 1'b1, s); // preamble on the first frame after each reset only
    end
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(!(op == `MGMT_OP_READ && i < 18), f[i], s); // released from turnaround
      if (i >= 1 && i <= 16) r = {r[14:0], s};
    end
    bit_cyc(1'b0, 1'b1, s); // one released idle bit
    if (op == `MGMT_OP_READ) begin
      rd_data <= r;
      rd_valid <= 1'b1;
      @(posedge core_clk);
      rd_valid <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/port_ctrl_tb_top.sv
// Purpose: self-checking bench for port_ctrl
// Assumes: 40 MHz core clock, mgmt clock of 16 core cycles
// Notes: read words checked against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_regs.vh"
module port_ctrl_tb_top;
  localparam logic [4:0] PA = 5'h05;
  logic core_clk = 1'b0, rst_b = 1'b0, fib = 1'b0, dled = 1'b0, strap = 1'b0;
  logic an_s = 1'b1, an_f = 1'b1, txm = 1'b0, rxl = 1'b0, mdio_wire, first_f, prev;
  wire mdc, mdio_o, mdio_oe, mdio_m, mdio_m_oe, rd_valid, rx_to_mac, tx_to_line;
  wire port_rst, port_enable, an_enable, an_restart, link_speed_100, link_full_duplex;
  wire [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [31:0] rnd = 32'h508a;
  int error_cnt = 0, checked = 0, cyc = 0, rs_cnt = 0, pr_cnt = 0;
  always #12.5 core_clk = ~core_clk;
  assign mdio_wire = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'b1); // pull-up
  port_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .phy_addr(PA), .mdc(mdc),
    .mdio_i(mdio_wire), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .fiber_mode(fib),
    .direct_led(dled), .duplex_strap(strap), .an_speed_100(an_s), .an_full_duplex(an_f),
    .tx_from_mac(txm), .rx_from_line(rxl), .rx_to_mac(rx_to_mac), .tx_to_line(tx_to_line),
    .port_rst(port_rst), .port_enable(port_enable), .an_enable(an_enable),
    .an_restart(an_restart), .link_speed_100(link_speed_100),
    .link_full_duplex(link_full_duplex));
  mac_mgmt i_mac (.core_clk(core_clk), .mdio_wire(mdio_wire), .mdc(mdc), .mdio_m(mdio_m),
    .mdio_m_oe(mdio_m_oe), .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t pin %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] e);
    exp_q.push_back(e);
    i_mac.frame(first_f, `MGMT_OP_READ, PA, `CTRL_REG_ADDR, 16'h0000);
    first_f = 1'b0;
  endtask
  task automatic wr(input logic [15:0] d);
    rnd = xs(rnd);
    i_mac.frame(first_f, `MGMT_OP_WRITE, PA, `CTRL_REG_ADDR, d | {8'h00, rnd[7:0]});
    first_f = 1'b0;
  endtask
  task automatic do_rst(input logic f, input logic d, input logic s);
    rst_b <= 1'b0;
    fib <= f;
    dled <= d;
    strap <= s;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (28000) @(posedge core_clk); // master idle 700 us after reset
    first_f = 1'b1;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (an_restart === 1'b1) rs_cnt++;
    if (port_rst === 1'b1) pr_cnt++;
    if (rd_valid === 1'b1) begin
      checked++;
      if (rd_data !== exp_q[0]) begin
        error_cnt++;
        $display("ERROR %0t read %h, expected %h", $time, rd_data, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    @(posedge core_clk);
    do_rst(1'b0, 1'b0, 1'b0);
    rd(16'h3100);
    an_s <= 1'b0;
    an_f <= 1'b0;
    rd(16'h1000);
    an_s <= 1'b1;
    an_f <= 1'b1;
    wr(16'h0000);
    rd(16'h0000);
    chk(an_enable, 1'b0);
    chk(link_speed_100, 1'b0);
    chk(link_full_duplex, 1'b0);
    wr(16'h2100);
    rd(16'h2100);
    chk(link_full_duplex, 1'b1);
    chk(link_speed_100, 1'b1);
    @(posedge core_clk);
    txm <= 1'b1;
    rxl <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(tx_to_line, 1'b1);
    chk(rx_to_mac, 1'b0);
    @(posedge core_clk);
    wr(16'h4000);
    repeat (20) begin
      @(posedge core_clk);
      rnd = xs(rnd);
      prev = txm;
      txm <= rnd[0];
      rxl <= rnd[1];
      @(negedge core_clk);
      chk(rx_to_mac, prev);
      chk(tx_to_line, 1'b0);
    end
    @(posedge core_clk);
    rxl <= 1'b1;
    txm <= 1'b1;
    wr(16'h0400);
    @(negedge core_clk);
    chk(rx_to_mac, 1'b0);
    chk(tx_to_line, 1'b0);
    @(posedge core_clk);
    rd(16'h0400);
    wr(16'h0800);
    chk(port_enable, 1'b0);
    chk(tx_to_line, 1'b0);
    rd(16'h0800);
    an_f <= 1'b0;
    wr(16'h1000);
    wr(16'h1200);
    chk(rs_cnt == 1, 1'b1);
    wr(16'h1100);
    chk(link_speed_100, 1'b1);
    chk(an_enable, 1'b1);
    chk(link_full_duplex, 1'b0);
    rd(16'h3000);
    an_f <= 1'b1;
    pr_cnt = 0;
    wr(16'h8800);
    chk(pr_cnt >= `SOFT_RST_CYCLES, 1'b1);
    rd(16'h3100);
    chk(port_enable, 1'b1);
    do_rst(1'b1, 1'b0, 1'b0);
    rd(16'h2000);
    wr(16'h1100);
    rd(16'h0100);
    chk(an_enable, 1'b0);
    wr(16'h8000);
    rd(16'h2000);
    tally_and_finish;
  end
endmodule
bind port_ctrl port_ctrl_props i_props (.core_clk(core_clk), .rst_b(rst_b), .phy_addr(phy_addr),
  .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .fiber_mode(fiber_mode),
  .direct_led(direct_led), .duplex_strap(duplex_strap), .an_speed_100(an_speed_100),
  .an_full_duplex(an_full_duplex), .tx_from_mac(tx_from_mac), .rx_from_line(rx_from_line),
  .rx_to_mac(rx_to_mac), .tx_to_line(tx_to_line), .port_rst(port_rst),
  .port_enable(port_enable), .an_enable(an_enable), .an_restart(an_restart),
  .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex));
`default_nettype wire
